// *** vtl_pkg.sv ***
// Purpose: Constants and types for the video timing input and low lane block
// Assumes: Parallel clock is i_clk; host reaches registers over Avalon-MM
// Notes:   Operation list below, one line for each behaviour of the block
//
// Operation
// R1: External timing and processing on: V flag follows V blanking input.
// R2: Source holds V blanking high through vertical blanking, low elsewhere.
// R3: V blanking input ignored while embedded timing is selected.
// R4: External timing and processing on: H flag follows H blanking input.
// R5: Host-writable H style bit lives in the processing-disable register.
// R6: Style 0, reset default: H high across blanking including EAV and SAV.
// R7: Style 1: H high only where received TRS H bit marks blanking.
// R8: Low lane is ten bits, bit 9 most significant, bit 0 least.
// R9: 20-bit bus, SMPTE processing, async stream off: low lane carries chroma.
// R10: 20-bit bus, processing bypassed, async stream off: low lane passes through.
// R11: 10-bit bus at either rate: low lane inputs held high impedance.
// R12: SD 20-bit async stream with bypass: low lane inputs high impedance.
// R13: Timing select high locks flywheel to embedded TRS; low to external inputs.
// R14: Blanking inputs and low lane sampled on rising parallel clock edge.
`default_nettype none

package vtl_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [3:0] VTL_ADDR_PROC_DIS = 4'h0;
  localparam logic [3:0] VTL_ADDR_STATUS   = 4'h4;

  // Processing-disable register fields
  localparam int         VTL_H_STYLE_BIT   = 0;
  localparam logic       VTL_H_STYLE_RST   = 1'b0;

  // Status register fields
  localparam int         VTL_ST_TSEL_BIT   = 0;
  localparam int         VTL_ST_IOEN_BIT   = 1;
  localparam int         VTL_ST_RATE_BIT   = 2;
  localparam int         VTL_ST_WIDTH_BIT  = 3;
  localparam int         VTL_ST_VPS_BIT    = 4;
  localparam int         VTL_ST_ASI_BIT    = 5;
  localparam int         VTL_ST_MODE_LSB   = 6;
  localparam int         VTL_ST_VFLAG_BIT  = 8;
  localparam int         VTL_ST_HFLAG_BIT  = 9;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int         VTL_LANE_W        = 10;
  localparam int         VTL_CTRL_W        = 6;
  localparam logic [9:0] VTL_LANE_RST      = 10'h000;
  localparam logic [31:0] VTL_RDATA_RST    = 32'h0000_0000;

  // Low lane routing modes
  typedef enum logic [1:0] {
    LANE_HIZ,
    LANE_CHROMA,
    LANE_THRU
  } vtl_lane_mode_t;

  // Bus slave states
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } vtl_bus_st_t;

endpackage

`default_nettype wire

// *** vtl_sync2.sv ***
// Purpose: Two-stage synchroniser for a group of level signals
// Assumes: Inputs are slow levels; no multi-bit coherence is needed
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module vtl_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// *** vtl_video_timing_input.sv ***
// Purpose: Blanking inputs to TRS flags, H style register, low lane routing
// Assumes: i_clk is the parallel clock; V, H and low lane are synchronous to it
// Notes:   Mode pins are asynchronous levels and pass a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none

module vtl_video_timing_input
  import vtl_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Mode pins
  input  wire logic        i_timing_source_sel,
  input  wire logic        i_io_processing_enable,
  input  wire logic        i_rate_select,
  input  wire logic        i_bus_width_select,
  input  wire logic        i_video_processing_select,
  input  wire logic        i_async_stream_select,
  // Blanking inputs and low lane
  input  wire logic        i_v_blank,
  input  wire logic        i_h_blank,
  input  wire logic [9:0]  i_low_lane,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // To TRS generation and flywheel
  output logic             o_v_flag,
  output logic             o_h_flag,
  output logic             o_h_style,
  output logic             o_flywheel_ext_lock,
  // Low lane towards the data path
  output logic             o_low_lane_in_en,
  output logic             o_low_lane_chroma,
  output logic             o_low_lane_thru,
  output logic      [9:0]  o_low_lane_data
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [VTL_CTRL_W-1:0] ctrl_async;
  logic [VTL_CTRL_W-1:0] ctrl_sync;
  logic                  s_tsel;
  logic                  s_ioen;
  logic                  s_rate;
  logic                  s_width;
  logic                  s_vps;
  logic                  s_asi;
  logic                  ext_timing;
  vtl_lane_mode_t        lane_mode;

  logic                  v_flag_q;
  logic                  h_flag_q;
  logic                  h_style_q;
  logic                  ext_lock_q;
  logic                  in_en_q;
  logic                  chroma_q;
  logic                  thru_q;
  logic [9:0]            low_data_q;
  vtl_lane_mode_t        mode_q;

  vtl_bus_st_t           bus_st_q;
  logic                  wait_q;
  logic [31:0]           rdata_q;
  logic                  req;
  logic                  take;

  // ==========================================================================
  // Mode pin synchronisation
  // ==========================================================================
  assign ctrl_async = {i_async_stream_select, i_video_processing_select, i_bus_width_select,
                       i_rate_select, i_io_processing_enable, i_timing_source_sel};

  vtl_sync2 #(
    .WIDTH (VTL_CTRL_W)
  ) u_ctrl_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (ctrl_async),
    .o_sync  (ctrl_sync)
  );

  assign s_tsel  = ctrl_sync[0];
  assign s_ioen  = ctrl_sync[1];
  assign s_rate  = ctrl_sync[2];
  assign s_width = ctrl_sync[3];
  assign s_vps   = ctrl_sync[4];
  assign s_asi   = ctrl_sync[5];

  // Flags from the pins only count with external timing and processing on
  assign ext_timing = !s_tsel && s_ioen;

  // ==========================================================================
  // Low lane mode decode
  // ==========================================================================
  // HD 20-bit with async stream is not a legal mode; parked in high impedance
  function automatic vtl_lane_mode_t lane_decode(input logic width, input logic asi,
                                                 input logic vps);
    vtl_lane_mode_t m;
    m = LANE_HIZ;
    if (!width)
      m = LANE_HIZ;                          // [R11]
    else if (asi)
      m = LANE_HIZ;                          // [R12]
    else if (vps)
      m = LANE_CHROMA;                       // [R9]
    else
      m = LANE_THRU;                         // [R10]
    return m;
  endfunction

  assign lane_mode = lane_decode(s_width, s_asi, s_vps);

  // ==========================================================================
  // Vertical flag
  // ==========================================================================
  // Sampled on the rising clock; V is in this clock's domain, no synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      v_flag_q <= 1'b0;
    else
      v_flag_q <= ext_timing && i_v_blank;   // [R1] [R3] [R14]
  end

  // ==========================================================================
  // Horizontal flag
  // ==========================================================================
  // Style only changes what the source drives; the flag copies H either way
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      h_flag_q <= 1'b0;
    else
      h_flag_q <= ext_timing && i_h_blank;   // [R4] [R14]
  end

  // ==========================================================================
  // Flywheel lock source
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ext_lock_q <= 1'b0;
    else
      ext_lock_q <= !s_tsel;                 // [R13]
  end

  // ==========================================================================
  // Low lane capture and routing
  // ==========================================================================
  // Data is zeroed while the lane is high impedance so nothing floats inward
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q     <= LANE_HIZ;
      in_en_q    <= 1'b0;
      chroma_q   <= 1'b0;
      thru_q     <= 1'b0;
      low_data_q <= VTL_LANE_RST;
    end
    else
    begin
      mode_q     <= lane_mode;
      in_en_q    <= (lane_mode != LANE_HIZ);                   // [R11] [R12]
      chroma_q   <= (lane_mode == LANE_CHROMA);                // [R9]
      thru_q     <= (lane_mode == LANE_THRU);                  // [R10]
      low_data_q <= (lane_mode != LANE_HIZ) ? i_low_lane[9:0]  // [R8] [R14]
                                            : VTL_LANE_RST;
    end
  end

  // ==========================================================================
  // Avalon-MM slave
  // ==========================================================================
  // One wait cycle per access keeps read data a plain flop
  assign req  = i_avs_read || i_avs_write;
  assign take = (bus_st_q == BUS_IDLE) && req;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_st_q <= BUS_IDLE;
      wait_q   <= 1'b1;
    end
    else
    begin
      case (bus_st_q)
        BUS_IDLE:
        begin
          if (req)
          begin
            bus_st_q <= BUS_ACK;
            wait_q   <= 1'b0;
          end
        end
        BUS_ACK:
        begin
          bus_st_q <= BUS_IDLE;
          wait_q   <= 1'b1;
        end
        default:
        begin
          bus_st_q <= BUS_IDLE;
          wait_q   <= 1'b1;
        end
      endcase
    end
  end

  // H style register; write lands at the edge the transfer completes
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      h_style_q <= VTL_H_STYLE_RST;                                 // [R6]
    else if ((bus_st_q == BUS_ACK) && i_avs_write && i_avs_byteenable[0]
             && (i_avs_address == VTL_ADDR_PROC_DIS))
      h_style_q <= i_avs_writedata[VTL_H_STYLE_BIT];                // [R5] [R7]
  end

  // Read data captured when the request is taken; unmapped reads zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= VTL_RDATA_RST;
    else if (take)
    begin
      rdata_q <= VTL_RDATA_RST;
      if (i_avs_read && (i_avs_address == VTL_ADDR_PROC_DIS))
        rdata_q[VTL_H_STYLE_BIT] <= h_style_q;
      else if (i_avs_read && (i_avs_address == VTL_ADDR_STATUS))
      begin
        rdata_q[VTL_ST_TSEL_BIT]                     <= s_tsel;
        rdata_q[VTL_ST_IOEN_BIT]                     <= s_ioen;
        rdata_q[VTL_ST_RATE_BIT]                     <= s_rate;
        rdata_q[VTL_ST_WIDTH_BIT]                    <= s_width;
        rdata_q[VTL_ST_VPS_BIT]                      <= s_vps;
        rdata_q[VTL_ST_ASI_BIT]                      <= s_asi;
        rdata_q[VTL_ST_MODE_LSB+1:VTL_ST_MODE_LSB]   <= mode_q;
        rdata_q[VTL_ST_VFLAG_BIT]                    <= v_flag_q;
        rdata_q[VTL_ST_HFLAG_BIT]                    <= h_flag_q;
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_avs_readdata      = rdata_q;
  assign o_avs_waitrequest   = wait_q;
  assign o_v_flag            = v_flag_q;
  assign o_h_flag            = h_flag_q;
  assign o_h_style           = h_style_q;
  assign o_flywheel_ext_lock = ext_lock_q;
  assign o_low_lane_in_en    = in_en_q;
  assign o_low_lane_chroma   = chroma_q;
  assign o_low_lane_thru     = thru_q;
  assign o_low_lane_data     = low_data_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_bus_taken;
    (bus_st_q == BUS_IDLE) && req;
  endsequence

  sequence s_bus_done;
    !wait_q ##1 wait_q;
  endsequence

  property p_v_follow;
    (ext_timing && i_v_blank) |=> o_v_flag;
  endproperty
  a_v_follow: assert property (p_v_follow) else $error("V flag missed blanking"); // [R1]

  property p_v_ignored;
    s_tsel |=> !o_v_flag;
  endproperty
  a_v_ignored: assert property (p_v_ignored) else $error("V used with embedded timing"); // [R3]

  property p_h_follow;
    ##1 (o_h_flag == $past(ext_timing && i_h_blank));
  endproperty
  a_h_follow: assert property (p_h_follow) else $error("H flag wrong"); // [R4]

  property p_h_style_write;
    ((bus_st_q == BUS_ACK) && i_avs_write && i_avs_byteenable[0]
      && (i_avs_address == VTL_ADDR_PROC_DIS))
      |=> (o_h_style == $past(i_avs_writedata[VTL_H_STYLE_BIT]));
  endproperty
  a_h_style_write: assert property (p_h_style_write) else $error("H style not stored"); // [R5]

  property p_chroma;
    (s_width && !s_asi && s_vps) |=> (o_low_lane_chroma && o_low_lane_in_en && !o_low_lane_thru);
  endproperty
  a_chroma: assert property (p_chroma) else $error("Chroma lane not selected"); // [R9]

  property p_thru;
    (s_width && !s_asi && !s_vps) |=> (o_low_lane_thru && !o_low_lane_chroma);
  endproperty
  a_thru: assert property (p_thru) else $error("Pass-through lane not selected"); // [R10]

  property p_narrow_hiz;
    !s_width |=> (!o_low_lane_in_en && (o_low_lane_data == VTL_LANE_RST));
  endproperty
  a_narrow_hiz: assert property (p_narrow_hiz) else $error("Lane live on 10-bit bus"); // [R11]

  property p_asi_hiz;
    (s_rate && s_width && s_asi && !s_vps) |=> !o_low_lane_in_en;
  endproperty
  a_asi_hiz: assert property (p_asi_hiz) else $error("Lane live in async stream"); // [R12]

  property p_bit_order;
    o_low_lane_in_en |-> (o_low_lane_data[9] == $past(i_low_lane[9]))
                         && (o_low_lane_data[0] == $past(i_low_lane[0]));
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("Low lane bit order broken"); // [R8]

  property p_lock_src;
    s_tsel [*2] |-> !o_flywheel_ext_lock;
  endproperty
  a_lock_src: assert property (p_lock_src) else $error("Flywheel lock source wrong"); // [R13]

  property p_bus_answer;
    s_bus_taken |=> s_bus_done;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus answer not one cycle"); // [R5]

endmodule

`default_nettype wire

// *** vtl_src_model.sv ***
// Purpose: Upstream video source model driving blanking inputs and low lane
// Assumes: Outputs change only right after the rising parallel clock edge
// Notes:   Short line and frame lengths keep the run brief
`timescale 1ns/1ps
`default_nettype none

module vtl_src_model #(
  parameter int LINE_LEN    = 16,
  parameter int FRAME_LINES = 8,
  parameter int V_LINES     = 2
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_style,
  output logic            o_v_blank,
  output logic            o_h_blank,
  output logic      [9:0] o_low_lane
);
  int pos_q;
  int line_q;

  // ==========================================================================
  // Raster position and outputs, all stepped on the rising edge
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pos_q      <= 0;
      line_q     <= 0;
      o_v_blank  <= 1'b0;
      o_h_blank  <= 1'b0;
      o_low_lane <= 10'h000;
    end
    else
    begin
      pos_q      <= (pos_q == LINE_LEN - 1) ? 0 : pos_q + 1;
      if (pos_q == LINE_LEN - 1)
      begin
        line_q <= (line_q == FRAME_LINES - 1) ? 0 : line_q + 1;
      end
      o_v_blank  <= (line_q < V_LINES);
      // Style 0 widens blanking by the EAV and SAV words
      o_h_blank  <= i_style ? (pos_q >= 1 && pos_q <= 4) : (pos_q < 6);
      o_low_lane <= o_low_lane + 10'h15B;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for blanking flags, H style and low lane routing
// Assumes: Avalon-MM master speaks one request at a time
// Notes:   Each mode entry is laid out like the status register low byte
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import vtl_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [5:0]  pins = 6'h00;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdata;
  logic        waitreq;
  logic        vb, hb, v_s, h_s, style_r = 1'b0;
  logic [9:0]  lane, lane_s;
  logic        vf, hf, hsty, fly, len, lch, lth;
  logic [9:0]  ldat;
  logic [31:0] q;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  // Mode entries: [7:6] lane mode, [5] async, [4] proc, [3] width, [2] rate, [1] io, [0] timing
  logic [7:0]  modes [6] = '{8'h5A, 8'h8F, 8'h88, 8'h12, 8'h26, 8'h2E};

  // ==========================================================================
  // Clock, timeout and sampled copies of the source outputs
  // ==========================================================================
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    v_s    <= vb;
    h_s    <= hb;
    lane_s <= lane;
    cyc    <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  vtl_src_model src (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_style(style_r),
    .o_v_blank(vb), .o_h_blank(hb), .o_low_lane(lane));

  vtl_video_timing_input dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_timing_source_sel(pins[0]), .i_io_processing_enable(pins[1]), .i_rate_select(pins[2]),
    .i_bus_width_select(pins[3]), .i_video_processing_select(pins[4]), .i_async_stream_select(pins[5]),
    .i_v_blank(vb), .i_h_blank(hb), .i_low_lane(lane),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .o_v_flag(vf), .o_h_flag(hf), .o_h_style(hsty), .o_flywheel_ext_lock(fly),
    .o_low_lane_in_en(len), .o_low_lane_chroma(lch), .o_low_lane_thru(lth), .o_low_lane_data(ldat));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus access; request held until waitrequest is seen low
  // No local limit: a slave that never answers is caught by the cycle ceiling
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    do
    begin
      @(posedge i_clk);
    end
    while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Apply one mode, let the synchroniser settle, then watch a frame and more
  task automatic run_mode(input logic [7:0] e);
    logic ext;
    ext = !e[0] && e[1];
    @(posedge i_clk);
    pins <= e[5:0];
    repeat (4) @(posedge i_clk);
    bus(1'b0, VTL_ADDR_STATUS, 32'h0000_0000);
    check("status", {24'h000000, q[7:0]}, {24'h000000, e});
    repeat (140)
    begin
      @(negedge i_clk);
      check("v_flag", vf, ext && v_s);
      check("h_flag", hf, ext && h_s);
      check("ext_lock", fly, !e[0]);
      check("lane_en", len, e[7:6] != 2'b00);
      check("lane_chroma", lch, e[7:6] == 2'b01);
      check("lane_thru", lth, e[7:6] == 2'b10);
      check("lane_data", ldat, (e[7:6] != 2'b00) ? lane_s : 10'h000);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, VTL_ADDR_PROC_DIS, 32'h0000_0000);
    check("proc_dis_rst", q, 32'h0000_0000);
    check("h_style_rst", hsty, VTL_H_STYLE_RST);
    bus(1'b1, VTL_ADDR_PROC_DIS, 32'h0000_0001);
    style_r <= 1'b1;
    bus(1'b0, VTL_ADDR_PROC_DIS, 32'h0000_0000);
    check("proc_dis_rw", q, 32'h0000_0001);
    check("h_style_set", hsty, 1'b1);
    // Unmapped and read-only places must leave the style bit alone
    bus(1'b0, 4'h8, 32'h0000_0000);
    check("unmapped_rd", q, 32'h0000_0000);
    bus(1'b1, 4'hC, 32'h0000_0000);
    bus(1'b1, VTL_ADDR_STATUS, 32'h0000_0000);
    // A write with lane 0 disabled must not touch the style bit either
    be <= 4'h0;
    bus(1'b1, VTL_ADDR_PROC_DIS, 32'h0000_0000);
    be <= 4'hF;
    bus(1'b0, VTL_ADDR_PROC_DIS, 32'h0000_0000);
    check("proc_dis_keep", q, 32'h0000_0001);
    for (int i = 0; i < 6; i++)
      run_mode(modes[i]);
    bus(1'b1, VTL_ADDR_PROC_DIS, 32'h0000_0000);
    style_r <= 1'b0;
    // The write lands on the edge the task returns at; look once it has settled
    @(negedge i_clk);
    check("h_style_clr", hsty, 1'b0);
    run_mode(modes[0]);
    finish_test();
  end
endmodule
`default_nettype wire
